//--- src/lof_top.v
`include "lof_consts.vh"
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module lof_top #(
   parameter WAKE_BASE_CYC = `LOF_WAKE_BASE_CYC,
   parameter FILT_CYC      = `LOF_FILT_CYC,
   parameter LP_DELAY_CYC  = `LOF_LP_DELAY_CYC,
   parameter AUX_MAX       = 8
) (
   input  wire        i_clk_sys,
   input  wire        i_rst,
   // Register port from serial interface
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   input  wire [7:0]  i_reg_addr,
   input  wire [7:0]  i_reg_wdata,
   output reg  [7:0]  o_reg_rdata,
   output reg         o_reg_hit,
   // Mode and sensor data
   input  wire        i_low_power,
   input  wire [15:0] i_temp,
   input  wire [15:0] i_rate_x,
   input  wire [15:0] i_rate_y,
   input  wire [15:0] i_rate_z,
   input  wire [15:0] i_accel_x,
   input  wire [15:0] i_accel_y,
   input  wire [15:0] i_accel_z,
   input  wire [3:0]  i_aux0_len,
   input  wire [3:0]  i_aux1_len,
   input  wire [3:0]  i_aux2_len,
   input  wire [3:0]  i_aux3_len,
   input  wire [7:0]  i_ext_byte,
   output reg  [4:0]  o_ext_idx,
   // Accelerometer power and FIFO push port
   output reg         o_accel_wake,
   output wire [7:0]  o_motion_thr,
   output wire [11:0] o_motion_thr_mg,
   output reg         o_fifo_push,
   output reg  [7:0]  o_fifo_data,
   input  wire        i_fifo_ready,
   output reg         o_sample_tick,
   output wire        o_wake_code_bad
);
   // Write sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_SRC  = 2'h1;
   localparam ST_BYTE = 2'h2;

   // Register bank
   reg  [7:0]  wake_rate_q;
   reg  [7:0]  motion_thr_q;
   reg  [7:0]  fifo_sel_q;
   reg  [7:0]  sample_div_q;
   reg  [7:0]  aux3_ctrl_q;
   // Wake and sample pacing
   reg  [31:0] wake_period;
   reg  [3:0]  wake_shift;
   wire        wake_tick;
   wire        filt_tick;
   wire        smp_tick;
   reg  [31:0] awake_cnt_q;
   // Write sequencer
   reg  [1:0]  st_q;
   reg  [3:0]  src_q;
   reg  [3:0]  byte_q;
   reg  [3:0]  nbytes;
   reg  [8:0]  pend_q;
   reg  [127:0] snap_q;
   reg  [4:0]  ext_base;
   reg  [4:0]  ext_off;
   // Source scan
   reg  [8:0]  en_vec;
   integer     k;
   reg  [3:0]  first_src;
   reg         found;

   //////////////////////////////////////////////////////////////////////////
   // Register writes; threshold resets to zero
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         wake_rate_q  <= `LOF_RST_WAKE_RATE;
         motion_thr_q <= `LOF_RST_MOTION_THR;
         fifo_sel_q   <= `LOF_RST_FIFO_SEL;
         sample_div_q <= `LOF_RST_SAMPLE_DIV;
         aux3_ctrl_q  <= `LOF_RST_AUX3_CTRL;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `LOF_ADDR_WAKE_RATE:  wake_rate_q  <= {4'h0, i_reg_wdata[3:0]};
            `LOF_ADDR_MOTION_THR: motion_thr_q <= i_reg_wdata;
            `LOF_ADDR_FIFO_SEL:   fifo_sel_q   <= i_reg_wdata;
            `LOF_ADDR_SAMPLE_DIV: sample_div_q <= i_reg_wdata;
            `LOF_ADDR_AUX3_CTRL:  aux3_ctrl_q  <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Registered read data; unmapped addresses read zero
   // Reserved wake bits were dropped on write, so they read back zero
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
         o_reg_hit   <= 1'b0;
      end else begin
         o_reg_hit <= 1'b0;
         if (i_reg_rd) begin
            o_reg_hit <= 1'b1;
            case (i_reg_addr)
               `LOF_ADDR_WAKE_RATE:  o_reg_rdata <= wake_rate_q;
               `LOF_ADDR_MOTION_THR: o_reg_rdata <= motion_thr_q;
               `LOF_ADDR_FIFO_SEL:   o_reg_rdata <= fifo_sel_q;
               `LOF_ADDR_SAMPLE_DIV: o_reg_rdata <= sample_div_q;
               `LOF_ADDR_AUX3_CTRL:  o_reg_rdata <= aux3_ctrl_q;
               default: begin
                  o_reg_rdata <= 8'h00;
                  o_reg_hit   <= 1'b0;
               end
            endcase
         end
      end
   end

   // Threshold shared by all three axes, shown in milli-g too
   assign o_motion_thr    = motion_thr_q;
   assign o_motion_thr_mg = {2'b00, motion_thr_q, 2'b00};
   assign o_wake_code_bad = (wake_rate_q[3:0] > `LOF_WAKE_CODE_MAX);

   //////////////////////////////////////////////////////////////////////////
   // Doublings below the 500 Hz base for each wake code
   always @* begin
      case (wake_rate_q[3:0])
         4'h0:    wake_shift = 4'hB;
         4'h1:    wake_shift = 4'hA;
         4'h2:    wake_shift = 4'h9;
         4'h3:    wake_shift = 4'h8;
         4'h4:    wake_shift = 4'h7;
         4'h5:    wake_shift = 4'h6;
         4'h6:    wake_shift = 4'h5;
         4'h7:    wake_shift = 4'h4;
         4'h8:    wake_shift = 4'h3;
         4'h9:    wake_shift = 4'h2;
         4'hA:    wake_shift = 4'h1;
         4'hB:    wake_shift = 4'h0;
         default: wake_shift = 4'h0; // Reserved; period forced below
      endcase
   end

   // Wake period doubles per code step down from 500 Hz
   always @* begin
      if (wake_rate_q[3:0] > `LOF_WAKE_CODE_MAX) begin
         wake_period = 32'hFFFFFFFF;
      end else begin
         wake_period = (WAKE_BASE_CYC << wake_shift) - 1;
      end
   end

   // Held in reset outside low power, so each entry waits a full period
   lof_tick_div #(.W(32)) u_wake_div (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst | ~i_low_power),
      .i_en      (1'b1),
      .i_period  (wake_period),
      .o_tick    (wake_tick)
   );

   // Accelerometer awake for the 1 ms filter delay after each wake
   // Limitation: a wake period below the delay keeps it always awake
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         awake_cnt_q  <= 32'h0;
         o_accel_wake <= 1'b1;
      end else if (!i_low_power) begin
         awake_cnt_q  <= 32'h0;
         o_accel_wake <= 1'b1;
      end else if (wake_tick) begin
         awake_cnt_q  <= LP_DELAY_CYC;
         o_accel_wake <= 1'b1;
      end else if (awake_cnt_q != 32'h0) begin
         awake_cnt_q <= awake_cnt_q - 32'h1;
      end else begin
         o_accel_wake <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Filter rate, then divided by divider plus one
   lof_tick_div #(.W(32)) u_filt_div (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_en      (1'b1),
      .i_period  (FILT_CYC - 1),
      .o_tick    (filt_tick)
   );

   // A new divider applies once the running count meets it
   lof_tick_div #(.W(8)) u_smp_div (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_en      (filt_tick),
      .i_period  (sample_div_q),
      .o_tick    (smp_tick)
   );

   // Enables in write order; standby does not gate them
   always @* begin
      en_vec[0] = fifo_sel_q[`LOF_BIT_TEMP];
      en_vec[1] = fifo_sel_q[`LOF_BIT_RATE_X];
      en_vec[2] = fifo_sel_q[`LOF_BIT_RATE_Y];
      en_vec[3] = fifo_sel_q[`LOF_BIT_RATE_Z];
      en_vec[4] = fifo_sel_q[`LOF_BIT_ACCEL];
      en_vec[5] = fifo_sel_q[`LOF_BIT_AUX0];
      en_vec[6] = fifo_sel_q[`LOF_BIT_AUX1];
      en_vec[7] = fifo_sel_q[`LOF_BIT_AUX2];
      en_vec[8] = aux3_ctrl_q[`LOF_BIT_AUX3];
   end

   // Next pending source, lowest index first
   always @* begin
      first_src = `LOF_SRC_NONE;
      found     = 1'b0;
      for (k = 0; k < 9; k = k + 1) begin
         if (!found && pend_q[k]) begin
            first_src = k[3:0];
            found     = 1'b1;
         end
      end
   end

   // Byte count of the current source
   always @* begin
      case (src_q)
         `LOF_SRC_ACC:  nbytes = 4'h6;
         `LOF_SRC_AUX0: nbytes = i_aux0_len;
         `LOF_SRC_AUX1: nbytes = i_aux1_len;
         `LOF_SRC_AUX2: nbytes = i_aux2_len;
         `LOF_SRC_AUX3: nbytes = i_aux3_len;
         default:       nbytes = 4'h2;
      endcase
   end

   // Aux bytes follow each other in the external data area
   always @* begin
      case (src_q)
         `LOF_SRC_AUX1: ext_off = {1'b0, i_aux0_len};
         `LOF_SRC_AUX2: ext_off = {1'b0, i_aux0_len} + {1'b0, i_aux1_len};
         `LOF_SRC_AUX3: ext_off = {1'b0, i_aux0_len} + {1'b0, i_aux1_len}
                                  + {1'b0, i_aux2_len};
         default:       ext_off = 5'h00;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Write sequencer; a tick mid-burst is dropped, not queued
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_q          <= ST_IDLE;
         src_q         <= `LOF_SRC_NONE;
         byte_q        <= 4'h0;
         pend_q        <= 9'h000;
         snap_q        <= 128'h0;
         o_fifo_push   <= 1'b0;
         o_fifo_data   <= 8'h00;
         o_sample_tick <= 1'b0;
      end else begin
         o_sample_tick <= smp_tick;
         if (o_fifo_push && !i_fifo_ready) begin
            o_fifo_push <= 1'b1; // Hold data until taken
         end else begin
            o_fifo_push <= 1'b0;
            case (st_q)
               // Snapshot all sensor words at once so one burst is coherent
               ST_IDLE: begin
                  if (smp_tick) begin
                     pend_q <= en_vec;
                     snap_q <= {i_temp, i_rate_x, i_rate_y, i_rate_z,
                                i_accel_x, i_accel_y, i_accel_z, 16'h0000};
                     st_q   <= ST_SRC;
                  end
               end
               // One cycle here per source, plus one in ST_BYTE after the last byte; lowest pending index goes first
               ST_SRC: begin
                  if (first_src == `LOF_SRC_NONE) begin
                     st_q <= ST_IDLE;
                  end else begin
                     src_q  <= first_src;
                     pend_q[first_src] <= 1'b0;
                     byte_q <= 4'h0;
                     st_q   <= ST_BYTE;
                  end
               end
               ST_BYTE: begin
                  if (byte_q == nbytes) begin
                     st_q <= ST_SRC;
                  end else begin
                     o_fifo_push <= 1'b1;
                     byte_q      <= byte_q + 4'h1;
                     case (src_q)
                        // High byte first for each 16-bit value
                        `LOF_SRC_TEMP: o_fifo_data <= snap_q[127-8*byte_q -: 8];
                        `LOF_SRC_RX:   o_fifo_data <= snap_q[111-8*byte_q -: 8];
                        `LOF_SRC_RY:   o_fifo_data <= snap_q[95-8*byte_q -: 8];
                        `LOF_SRC_RZ:   o_fifo_data <= snap_q[79-8*byte_q -: 8];
                        `LOF_SRC_ACC:  o_fifo_data <= snap_q[63-8*byte_q -: 8];
                        // Aux bytes come live from the outside area, not snapped
                        default: begin
                           o_fifo_data <= i_ext_byte;
                        end
                     endcase
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Address of the external byte sampled on the next cycle
   // Left combinational: the outside lookup must answer before that edge
   always @* begin
      ext_base  = ext_off + {1'b0, byte_q};
      o_ext_idx = ext_base;
   end
endmodule
`default_nettype wire

//--- src/lof_consts.vh
`ifndef LOF_CONSTS_VH
`define LOF_CONSTS_VH
// Register addresses on the serial register port
`define LOF_ADDR_WAKE_RATE    8'h1E
`define LOF_ADDR_MOTION_THR   8'h1F
`define LOF_ADDR_FIFO_SEL     8'h23
`define LOF_ADDR_SAMPLE_DIV   8'h19
`define LOF_ADDR_AUX3_CTRL    8'h24
// Reset values
`define LOF_RST_WAKE_RATE     8'h00
`define LOF_RST_MOTION_THR    8'h00
`define LOF_RST_FIFO_SEL      8'h00
`define LOF_RST_SAMPLE_DIV    8'h00
`define LOF_RST_AUX3_CTRL     8'h00
// Field positions in the source select register; AUX3 sits in the aux 3 control register
`define LOF_BIT_TEMP          7
`define LOF_BIT_RATE_X        6
`define LOF_BIT_RATE_Y        5
`define LOF_BIT_RATE_Z        4
`define LOF_BIT_ACCEL         3
`define LOF_BIT_AUX2          2
`define LOF_BIT_AUX1          1
`define LOF_BIT_AUX0          0
`define LOF_BIT_AUX3          5
// Wake rate codes
`define LOF_WAKE_CODE_MAX     4'hB
`define LOF_WAKE_FIELD_W      4
// Threshold scaling, milli-g per step
`define LOF_THR_MG_PER_STEP   4
// Low-power wake timing
`define LOF_CLK_HZ            125000000
`define LOF_LP_DELAY_US       1000
`define LOF_LP_DELAY_CYC      ((`LOF_LP_DELAY_US * (`LOF_CLK_HZ / 1000000)))
// Base period of the 500 Hz wake rate, in clock cycles
`define LOF_WAKE_BASE_CYC     (`LOF_CLK_HZ / 500)
// Filter output rate in low-power accel path, 1 kHz
`define LOF_FILT_RATE_HZ      1000
`define LOF_FILT_CYC          (`LOF_CLK_HZ / `LOF_FILT_RATE_HZ)
// Source codes for the write sequencer
`define LOF_SRC_TEMP          4'h0
`define LOF_SRC_RX            4'h1
`define LOF_SRC_RY            4'h2
`define LOF_SRC_RZ            4'h3
`define LOF_SRC_ACC           4'h4
`define LOF_SRC_AUX0          4'h5
`define LOF_SRC_AUX1          4'h6
`define LOF_SRC_AUX2          4'h7
`define LOF_SRC_AUX3          4'h8
`define LOF_SRC_NONE          4'hF
`endif

//--- src/lof_tick_div.v
`default_nettype none
// Programmable tick divider: pulse once every (period + 1) enables
module lof_tick_div #(
   parameter W = 32
) (
   input  wire         i_clk_sys,
   input  wire         i_rst,
   input  wire         i_en,
   input  wire [W-1:0] i_period,
   output reg          o_tick
);
   reg [W-1:0] cnt_q;

   // Count enables, reload on terminal count
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         cnt_q  <= {W{1'b0}};
         o_tick <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (i_en) begin
            if (cnt_q >= i_period) begin
               cnt_q  <= {W{1'b0}};
               o_tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- test/lof_top_sva.sv
`default_nettype none
// Port-level checks of register reads and writes, threshold, stalled push, accel wake and reset
module lof_top_sva (
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic [7:0]  o_reg_rdata,
   input wire logic        o_reg_hit,
   input wire logic        i_low_power,
   input wire logic        o_accel_wake,
   input wire logic [7:0]  o_motion_thr,
   input wire logic [11:0] o_motion_thr_mg,
   input wire logic        o_fifo_push,
   input wire logic [7:0]  o_fifo_data,
   input wire logic        i_fifo_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // Mapped reads, holes in the map, and a stalled push
   sequence s_rd_map;
      i_reg_rd && i_reg_addr inside {8'h19, 8'h1E, 8'h1F, 8'h23, 8'h24};
   endsequence
   sequence s_rd_hole;
      i_reg_rd && !(i_reg_addr inside {8'h19, 8'h1E, 8'h1F, 8'h23, 8'h24});
   endsequence
   sequence s_stall;
      o_fifo_push && !i_fifo_ready;
   endsequence
   property p_rd_hit;
      s_rd_map |=> o_reg_hit;
   endproperty
   a_rd_hit: assert property (p_rd_hit) else $error("mapped read gave no hit");
   property p_rd_hole;
      s_rd_hole |=> !o_reg_hit && o_reg_rdata == 8'h00;
   endproperty
   a_rd_hole: assert property (p_rd_hole) else $error("unmapped read answered");
   property p_rd_wake;
      i_reg_rd && i_reg_addr == 8'h1E |=> o_reg_rdata[7:4] == 4'h0;
   endproperty
   a_rd_wake: assert property (p_rd_wake) else $error("wake rate top bits set");
   property p_rd_thr;
      i_reg_rd && !i_reg_wr && i_reg_addr == 8'h1F |=> o_reg_rdata == o_motion_thr;
   endproperty
   a_rd_thr: assert property (p_rd_thr) else $error("threshold readback wrong");
   property p_wr_thr;
      i_reg_wr && i_reg_addr == 8'h1F |=> o_motion_thr == $past(i_reg_wdata);
   endproperty
   a_wr_thr: assert property (p_wr_thr) else $error("threshold not written");
   property p_thr_mg;
      o_motion_thr_mg == {2'b00, o_motion_thr, 2'b00};
   endproperty
   a_thr_mg: assert property (p_thr_mg) else $error("threshold scale wrong");
   property p_hold;
      s_stall |=> o_fifo_push && $stable(o_fifo_data);
   endproperty
   a_hold: assert property (p_hold) else $error("push dropped while stalled");
   property p_awake;
      !i_low_power [*2] |-> o_accel_wake;
   endproperty
   a_awake: assert property (p_awake) else $error("accel asleep in full power");
   property p_rst;
      $fell(i_rst) |-> o_motion_thr == 8'h00 && !o_fifo_push;
   endproperty
   a_rst: assert property (p_rst) else $error("threshold not cleared by reset");
endmodule
bind lof_top lof_top_sva u_sva (.i_clk_sys, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
   .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .i_low_power, .o_accel_wake, .o_motion_thr,
   .o_motion_thr_mg, .o_fifo_push, .o_fifo_data, .i_fifo_ready);
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic        i_low_power = 1'b0, i_fifo_ready = 1'b1;
   logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
   logic [15:0] sv [7] = '{default: 16'h0000};
   logic [3:0]  al [4] = '{4'h2, 4'h3, 4'h1, 4'h2};
   wire  [7:0]  i_ext_byte, o_reg_rdata, o_motion_thr, o_fifo_data;
   wire  [4:0]  o_ext_idx;
   wire  [11:0] o_motion_thr_mg;
   wire         o_reg_hit, o_accel_wake, o_fifo_push, o_sample_tick, o_wake_code_bad;
   logic [7:0]  got [$], exp [$];
   int          fail_count = 0, tests_run = 0, gap;
   // Rows: expected byte count, slave-3 enable, source select
   logic [16:0] rows [10] = '{{8'h02, 1'b0, 8'h80}, {8'h02, 1'b0, 8'h40},
      {8'h02, 1'b0, 8'h20}, {8'h02, 1'b0, 8'h10}, {8'h06, 1'b0, 8'h08},
      {8'h01, 1'b0, 8'h04}, {8'h03, 1'b0, 8'h02}, {8'h02, 1'b0, 8'h01},
      {8'h02, 1'b1, 8'h00}, {8'h00, 1'b0, 8'h00}};
   always #4 i_clk_sys = ~i_clk_sys;
   // Outside byte area: each index gives its own value
   assign i_ext_byte = 8'hE0 | {3'h0, o_ext_idx};
   // Short counts keep the run small; wake period above the awake time
   lof_top #(.WAKE_BASE_CYC(8), .FILT_CYC(4), .LP_DELAY_CYC(3)) dut (.i_clk_sys, .i_rst,
      .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_hit,
      .i_low_power, .i_temp(sv[0]), .i_rate_x(sv[1]), .i_rate_y(sv[2]), .i_rate_z(sv[3]),
      .i_accel_x(sv[4]), .i_accel_y(sv[5]), .i_accel_z(sv[6]), .i_aux0_len(al[0]),
      .i_aux1_len(al[1]), .i_aux2_len(al[2]), .i_aux3_len(al[3]), .i_ext_byte, .o_ext_idx,
      .o_accel_wake, .o_motion_thr, .o_motion_thr_mg, .o_fifo_push, .o_fifo_data,
      .i_fifo_ready, .o_sample_tick, .o_wake_code_bad);
   // Record every byte the FIFO accepts
   always @(posedge i_clk_sys) begin
      if (o_fifo_push === 1'b1 && i_fifo_ready)
         got.push_back(o_fifo_data);
   end
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1;
      chk(o_reg_rdata, e);
      chk(o_reg_hit, h);
   endtask
   // Bounded wait; gap holds the cycles waited
   task automatic wait_tick;
      gap = 0;
      do begin
         @(negedge i_clk_sys);
         gap++;
      end while (o_sample_tick !== 1'b1 && gap < 2000);
      chk(gap < 2000, 1);
   endtask
   // Expected order: temp, rates, accel, then aux bytes, high byte first
   task automatic build(input logic [7:0] sel, input logic a3);
      int b;
      b = 0;
      exp = {};
      for (int k = 0; k < 7; k++) begin
         if (sel[k < 4 ? 7 - k : 3]) begin
            exp.push_back(sv[k][15:8]);
            exp.push_back(sv[k][7:0]);
         end
      end
      for (int j = 0; j < 4; j++) begin
         for (int n = 0; n < al[j]; n++) begin
            if (j < 3 ? sel[j] : a3)
               exp.push_back(8'hE0 | 8'(b));
            b++;
         end
      end
   endtask
   // One tick's burst, optionally stalled by the FIFO at the start
   task automatic burst(input logic [7:0] sel, input logic a3, input int stall);
      wait_tick();
      got = {};
      @(posedge i_clk_sys);
      if (stall > 0) begin
         i_fifo_ready <= 1'b0;
         repeat (stall) @(posedge i_clk_sys);
         i_fifo_ready <= 1'b1;
      end
      repeat (100) @(posedge i_clk_sys);
      build(sel, a3);
      chk(got.size(), exp.size());
      foreach (exp[i])
         chk(i < got.size() ? got[i] : 8'hXX, exp[i]);
   endtask
   task end_sim;
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int n;
      logic [16:0] rw;
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      wr_reg(8'h19, 8'h3F);
      foreach (rows[r]) begin
         rw = rows[r];
         i_low_power <= r[0];
         foreach (sv[k])
            sv[k] <= 16'h1111 * 16'(k + 1) + 16'(r);
         wr_reg(8'h24, {2'b00, rw[8], 5'h00});
         wr_reg(8'h23, rw[7:0]);
         burst(rw[7:0], rw[8], 0);
         chk(got.size(), rw[16:9]);
      end
      // Stalled full burst, all sources on
      wr_reg(8'h24, 8'h20);
      wr_reg(8'h23, 8'hFF);
      burst(8'hFF, 1'b1, 6);
      // Tick spacing for two divider values
      foreach (rows[d]) begin
         if (d < 2) begin
            wr_reg(8'h19, d ? 8'h02 : 8'h0F);
            wait_tick();
            wait_tick();
            wait_tick();
            chk(gap, d ? 12 : 64);
         end
      end
      wr_reg(8'h1F, 8'hFF);
      rd_chk(8'h1F, 8'hFF, 1'b1);
      chk(o_motion_thr_mg, 12'h3FC);
      chk(o_motion_thr, 8'hFF);
      rd_chk(8'h50, 8'h00, 1'b0);
      wr_reg(8'h1E, 8'hFF);
      rd_chk(8'h1E, 8'h0F, 1'b1);
      chk(o_wake_code_bad, 1'b1);
      // Fastest wake rate duty-cycles, a reserved code stops waking
      wr_reg(8'h1E, 8'h0B);
      i_low_power <= 1'b1;
      #1;
      chk(o_wake_code_bad, 1'b0);
      repeat (10) @(posedge i_clk_sys);
      n = 0;
      repeat (40) begin
         @(posedge i_clk_sys);
         if (o_accel_wake === 1'b1)
            n++;
      end
      chk(n > 0 && n < 40, 1);
      wr_reg(8'h1E, 8'h0C);
      repeat (10) @(posedge i_clk_sys);
      n = 0;
      repeat (40) begin
         @(posedge i_clk_sys);
         if (o_accel_wake !== 1'b0)
            n++;
      end
      chk(n, 0);
      i_low_power <= 1'b0;
      // Second reset in mid-run clears the registers
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd_chk(8'h1F, 8'h00, 1'b1);
      rd_chk(8'h23, 8'h00, 1'b1);
      chk(o_accel_wake, 1'b1);
      end_sim();
   end
   // Watchdog well past the expected run length
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end
endmodule
`default_nettype wire
